// ### rtl/mec_maint_regs.sv
module mec_maint_regs
  import mec_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire mec_reg_req_type reg_req_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic [NUM_CH-1:0][LINE_SRC_W-1:0] line_status_i,
  input wire logic [NUM_CH-1:0][LINE_SRC_W-1:0] edge_select_i,
  input wire logic [NUM_CH-1:0][ERR_SRC_W-1:0] error_event_i,
  input wire logic [NUM_CH-1:0] one_second_tick_i,
  output mec_chan_cfg_type [NUM_CH-1:0] chan_cfg_o,
  output mec_chan_pulse_type [NUM_CH-1:0] chan_pulse_o,
  output logic [NUM_CH-1:0][LINE_SRC_W-1:0] line_irq_event_o,
  output logic [NUM_CH-1:0][ERR_SRC_W-1:0] error_irq_event_o
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [CH_W-1:0] ch,
                                   input logic [4:0] ofs);
    logic [ADDR_W-1:0] base;
    base = ADDR_W'(CH_STRIDE * ch);
    reg_hit = (addr == (base | {3'h0, ofs}));
  endfunction : reg_hit

  logic [NUM_CH-1:0][DATA_W-1:0] maint_q;
  logic [NUM_CH-1:0][DATA_W-1:0] maint_prev_q;
  logic [NUM_CH-1:0][DATA_W-1:0] mask_line_q;
  logic [NUM_CH-1:0][DATA_W-1:0] mask_err_q;
  logic [NUM_CH-1:0][LINE_SRC_W-1:0] status_prev_q;
  mec_chan_pulse_type [NUM_CH-1:0] pulse_q;
  logic [NUM_CH-1:0][LINE_SRC_W-1:0] line_irq_q;
  logic [NUM_CH-1:0][ERR_SRC_W-1:0] err_irq_q;
  logic [DATA_W-1:0] rdata_q;
  logic rvalid_q;

  logic [NUM_CH-1:0] hit_maint;
  logic [NUM_CH-1:0] hit_mask_line;
  logic [NUM_CH-1:0] hit_mask_err;
  logic [DATA_W-1:0] rdata_d;

  wire [CH_W-1:0] req_ch = reg_req_i.addr[ADDR_W-1:ADDR_W-CH_W];

  for (genvar c = 0; c < NUM_CH; c++) begin : g_dec
    assign hit_maint[c] = reg_hit(reg_req_i.addr, CH_W'(c), OFS_MAINT_CTRL);
    assign hit_mask_line[c] = reg_hit(reg_req_i.addr, CH_W'(c), OFS_MASK_LINE);
    assign hit_mask_err[c] = reg_hit(reg_req_i.addr, CH_W'(c), OFS_MASK_ERR);
  end

  wire any_maint = |hit_maint;
  wire any_mask_line = |hit_mask_line;
  wire any_mask_err = |hit_mask_err;

  assign rdata_d = any_maint ? maint_q[req_ch] :
                   any_mask_line ? mask_line_q[req_ch] :
                   any_mask_err ? mask_err_q[req_ch] : UNMAPPED_DATA;

  // ----------------------------------------------------------------
  // Per-channel registers and event logic
  // ----------------------------------------------------------------
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    logic [DATA_W-1:0] maint_wr;
    logic [DATA_W-1:0] mask_line_wr;
    logic [LINE_SRC_W-1:0] rise;
    logic [LINE_SRC_W-1:0] fall;
    mec_chan_pulse_type pulse_d;

    assign maint_wr = {RSVD_MAINT_VAL, reg_req_i.wdata[BIT_RSVD-1:0]};
    assign mask_line_wr = {RSVD_MASK_LINE_VAL, reg_req_i.wdata[BIT_RSVD-1:0]};

    // Rising transitions against the previous-clock value; counter transfer also on one_second_tick_i in automatic mode
    assign pulse_d.bipolar_violation_inject = maint_q[c][BIT_BPV_INJECT] &
                                              ~maint_prev_q[c][BIT_BPV_INJECT];
    assign pulse_d.pattern_error_inject = maint_q[c][BIT_PAT_INJECT] &
                                          ~maint_prev_q[c][BIT_PAT_INJECT];
    assign pulse_d.counter_transfer = (maint_q[c][BIT_CNT_XFER] & ~maint_prev_q[c][BIT_CNT_XFER]) |
                                      (maint_q[c][BIT_CNT_MODE] & one_second_tick_i[c]);

    assign rise = line_status_i[c] & ~status_prev_q[c];
    assign fall = ~line_status_i[c] & status_prev_q[c];

    assign chan_cfg_o[c].excess_zero_definition = maint_q[c][BIT_EXCESS_ZERO_DEFINITION];
    assign chan_cfg_o[c].count_select = mec_cnt_sel_type'(maint_q[c][BIT_CNT_SEL_HI:BIT_CNT_SEL_LO]);
    assign chan_cfg_o[c].counter_report_mode = maint_q[c][BIT_CNT_MODE];

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        maint_q[c] <= RST_MAINT_CTRL;
        mask_line_q[c] <= RST_MASK_LINE;
        mask_err_q[c] <= RST_MASK_ERR;
      end else if (reg_req_i.wr) begin
        if (hit_maint[c]) maint_q[c] <= maint_wr;
        if (hit_mask_line[c]) mask_line_q[c] <= mask_line_wr;
        if (hit_mask_err[c]) mask_err_q[c] <= reg_req_i.wdata;
      end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        maint_prev_q[c] <= RST_MAINT_CTRL;
        status_prev_q[c] <= '0;
        pulse_q[c] <= '0;
        line_irq_q[c] <= '0;
        err_irq_q[c] <= '0;
      end else begin
        maint_prev_q[c] <= maint_q[c];
        status_prev_q[c] <= line_status_i[c];
        pulse_q[c] <= pulse_d;
        line_irq_q[c] <= ~mask_line_q[c][LINE_SRC_W-1:0] & (rise | (edge_select_i[c] & fall));
        err_irq_q[c] <= ~mask_err_q[c] & error_event_i[c];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_q <= UNMAPPED_DATA;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_req_i.rd;
      if (reg_req_i.rd) rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign reg_rvalid_o = rvalid_q;
  assign chan_pulse_o = pulse_q;
  assign line_irq_event_o = line_irq_q;
  assign error_irq_event_o = err_irq_q;

endmodule : mec_maint_regs

// ### rtl/mec_pkg.sv
// Overview of operation
// - Rising edge of bit 6 inserts one bipolar violation; re-arm by clear then set.
// - Rising edge of bit 5 inserts one pattern logic error; re-arm by clear then set.
// - Bit 4 selects excess-zero criterion: 0 ANSI, 1 FCC.
// - Bits 3-2 select what the 16-bit error counter counts.
// - Bit 1 selects counter reporting: 0 manual, 1 automatic.
// - Rising edge of bit 0 transfers count to result registers and resets counter.
// - Eight channel copies at 10H, 30H, 50H...; stride 20H; masks repeat likewise.
// - Mask bit 0 enables, 1 suppresses; every mask bit resets to 1.
// - First mask: inband act, inband deact, sync, clock loss, driver fail, alarm, signal loss.
// - Second mask: dac ovf, jitter ovf, jitter unf, pattern err, excess zero, cv, timer, counter.
// - Edge select 0 makes rising status edge an event; 1 makes both edges events.
// - Status transition interrupts only when mask bit is 0 and edge matches.
package mec_pkg;

  localparam int NUM_CH = 8;
  localparam int CH_W = 3;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int LINE_SRC_W = 7;
  localparam int ERR_SRC_W = 8;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_MAINT_CTRL = 5'h10;
  localparam logic [4:0] OFS_MASK_LINE = 5'h11;
  localparam logic [4:0] OFS_MASK_ERR = 5'h12;
  localparam int CH_STRIDE = 32'h20;

  localparam logic [7:0] RST_MAINT_CTRL = 8'h00;
  localparam logic [7:0] RST_MASK_LINE = 8'hFF;
  localparam logic [7:0] RST_MASK_ERR = 8'hFF;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int BIT_RSVD = 7;
  localparam int BIT_BPV_INJECT = 6;
  localparam int BIT_PAT_INJECT = 5;
  localparam int BIT_EXCESS_ZERO_DEFINITION = 4;
  localparam int BIT_CNT_SEL_HI = 3;
  localparam int BIT_CNT_SEL_LO = 2;
  localparam int BIT_CNT_MODE = 1;
  localparam int BIT_CNT_XFER = 0;

  localparam logic RSVD_MAINT_VAL = 1'b0;
  localparam logic RSVD_MASK_LINE_VAL = 1'b1;

  typedef enum logic [1:0] {
    CNT_SEL_PATTERN = 2'h0,
    CNT_SEL_EXZ = 2'h1,
    CNT_SEL_BPV = 2'h2,
    CNT_SEL_BPV_EXZ = 2'h3
  } mec_cnt_sel_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mec_reg_req_type;

  typedef struct packed {
    logic excess_zero_definition;
    mec_cnt_sel_type count_select;
    logic counter_report_mode;
  } mec_chan_cfg_type;

  typedef struct packed {
    logic bipolar_violation_inject;
    logic pattern_error_inject;
    logic counter_transfer;
  } mec_chan_pulse_type;

endpackage : mec_pkg

// ### tb/mec_maint_regs_properties.sv
module mec_maint_regs_properties
  import mec_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire mec_reg_req_type reg_req_i,
  input wire logic [DATA_W-1:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic [NUM_CH-1:0][LINE_SRC_W-1:0] line_status_i,
  input wire logic [NUM_CH-1:0][LINE_SRC_W-1:0] edge_select_i,
  input wire logic [NUM_CH-1:0][ERR_SRC_W-1:0] error_event_i,
  input wire logic [NUM_CH-1:0] one_second_tick_i,
  input wire mec_chan_cfg_type [NUM_CH-1:0] chan_cfg_o,
  input wire mec_chan_pulse_type [NUM_CH-1:0] chan_pulse_o,
  input wire logic [NUM_CH-1:0][LINE_SRC_W-1:0] line_irq_event_o,
  input wire logic [NUM_CH-1:0][ERR_SRC_W-1:0] error_irq_event_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  AST_RVALID: assert property (reg_rvalid_o == $past(reg_req_i.rd))
    else $error("rvalid not one cycle after read");
  AST_UNMAPPED: assert property (reg_req_i.rd && reg_req_i.addr[4:0] > 5'h12 |=> reg_rdata_o == UNMAPPED_DATA)
    else $error("unmapped read not zero");
  AST_ONE_SHOT: assert property ((chan_pulse_o & $past(chan_pulse_o)) == '0)
    else $error("pulse longer than one cycle");
  AST_AUTO: assert property (one_second_tick_i[0] && chan_cfg_o[0].counter_report_mode |=> chan_pulse_o[0].counter_transfer)
    else $error("no transfer on tick");
  AST_CAUSE: assert property (chan_pulse_o[0] != '0 |-> $past(reg_req_i.wr) || $past(reg_req_i.wr, 2) || $past(one_second_tick_i[0]))
    else $error("pulse without cause");
  AST_CFG_HOLD: assert property (!reg_req_i.wr |=> $stable(chan_cfg_o))
    else $error("config changed without write");
  AST_ERR_IRQ: assert property ((error_irq_event_o & ~$past(error_event_i)) == '0)
    else $error("error event without source");
  AST_LINE_IRQ: assert property ((line_irq_event_o & ~($past(line_status_i) ^ $past(line_status_i, 2))) == '0)
    else $error("line event without change");
  AST_FALL: assert property ((line_irq_event_o & ~$past(edge_select_i) & ~$past(line_status_i) & $past(line_status_i, 2)) == '0)
    else $error("falling event in rising mode");
endmodule : mec_maint_regs_properties

bind mec_maint_regs mec_maint_regs_properties u_prop (.*);

// ### tb/mec_maint_regs_bench.sv
module mec_maint_regs_bench
  import mec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0;
  logic rst_b = 0;
  mec_reg_req_type req = '0;
  logic [7:0] rdata;
  logic rvalid;
  logic [7:0][6:0] ls = '0, es = '0, lev;
  logic [7:0][7:0] ee = '0, eev;
  logic [7:0] tick = '0;
  mec_chan_cfg_type [7:0] cfg;
  mec_chan_pulse_type [7:0] pls;
  int n_mismatch = 0, compares = 0, seed = 32'hB3E892E8, nb = 0, np = 0, nx = 0;
  always #4 clk = ~clk;
  always @(posedge clk) begin
    nb += pls[0].bipolar_violation_inject;
    np += pls[0].pattern_error_inject;
    nx += pls[0].counter_transfer;
  end
  mec_maint_regs uut (.core_clk_i(clk), .rst_b_i(rst_b), .reg_req_i(req), .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .line_status_i(ls), .edge_select_i(es), .error_event_i(ee),
    .one_second_tick_i(tick), .chan_cfg_o(cfg), .chan_pulse_o(pls), .line_irq_event_o(lev),
    .error_irq_event_o(eev));
  // ----
  // Helpers
  // ----
  function automatic logic [7:0] ad(int c, logic [4:0] o);
    return 8'(c * CH_STRIDE + o);
  endfunction : ad
  function automatic logic [6:0] lx(logic [6:0] m, e, n, p);
    return ~m & ((n & ~p) | (e & ~n & p));
  endfunction : lx
  task automatic chk(input logic [15:0] got, exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    req <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, e);
    @(posedge clk);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    req <= '0;
    #1 chk(16'(rvalid), 16'h0001);
    chk(16'(rdata), 16'(e));
  endtask : rd
  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    final_report();
  end
  initial begin
    logic [7:0] d, m, e1;
    logic [6:0] h1, h2;
    repeat (3) @(posedge clk);
    rst_b <= 1;
    for (int c = 0; c < 8; c++) begin
      rd(ad(c, OFS_MAINT_CTRL), RST_MAINT_CTRL);
      rd(ad(c, OFS_MASK_LINE), RST_MASK_LINE);
      rd(ad(c, OFS_MASK_ERR), RST_MASK_ERR);
      rd(ad(c, 5'h13), UNMAPPED_DATA);
      d = 8'($random(seed));
      d[3:2] = c[1:0];
      wr(ad(c, OFS_MAINT_CTRL), d);
      rd(ad(c, OFS_MAINT_CTRL), d & 8'h7F);
      chk(cfg[c], {d[4], d[3:2], d[1]});
      wr(ad(c, OFS_MASK_LINE), d);
      rd(ad(c, OFS_MASK_LINE), d | 8'h80);
      wr(ad(c, OFS_MASK_ERR), ~d);
      rd(ad(c, OFS_MASK_ERR), ~d);
    end
    wr(ad(0, OFS_MAINT_CTRL), 8'h00);
    repeat (3) @(posedge clk);
    nb = 0;
    np = 0;
    nx = 0;
    // Held bits re-arm only through a clear
    for (int k = 0; k < 2; k++) begin
      wr(ad(0, OFS_MAINT_CTRL), 8'h00);
      wr(ad(0, OFS_MAINT_CTRL), 8'h61);
      wr(ad(0, OFS_MAINT_CTRL), 8'h61);
    end
    repeat (3) @(posedge clk);
    chk({nb[3:0], np[3:0], nx[3:0]}, 16'h0222);
    for (int k = 0; k < 2; k++) begin
      wr(ad(0, OFS_MAINT_CTRL), k ? 8'h00 : 8'h02);
      tick[0] <= 1'b1;
      @(posedge clk);
      tick[0] <= 1'b0;
      repeat (3) @(posedge clk);
    end
    chk(16'(nx), 16'h0003);
    m = 8'($random(seed));
    wr(ad(2, OFS_MASK_LINE), m);
    wr(ad(2, OFS_MASK_ERR), m);
    es[2] <= 7'(m ^ 8'h5A);
    h1 = '0;
    for (int k = 0; k < 200; k++) begin
      @(posedge clk);
      h2 = h1;
      h1 = ls[2];
      e1 = ee[2];
      ls[2] <= (k < 199) ? 7'($random(seed)) : 7'h00;
      ee[2] <= (k < 199) ? 8'($random(seed)) : 8'h00;
      #1 chk(lev[2], lx(m[6:0], es[2], h1, h2));
      chk(eev[2], e1 & ~m);
    end
    rst_b <= 0;
    @(posedge clk);
    rst_b <= 1;
    rd(ad(0, OFS_MAINT_CTRL), RST_MAINT_CTRL);
    rd(ad(2, OFS_MASK_LINE), RST_MASK_LINE);
    final_report();
  end
endmodule : mec_maint_regs_bench
